// ---- design/dbc_chopper.sv ----
// dual bridge fixed frequency chopper with apb control registers
`timescale 1ns/1ps
`default_nettype none

// Function
// - flag overcurrent when supply to threshold drop exceeds 150 mV
// - chop both bridges at one frequency, half a period apart
// - each period runs on, then fast decay when mixed decay is enabled, then slow decay
// - fast decay: high sides off, only opposite low side on
// - slow decay: both low sides on whatever the polarity
// - polarity change restarts that bridge's period at once
// - mixed decay: longer on phase gives shorter fast decay
// - bridge a starts on oscillator rise, bridge b on fall
// - chopper clock from internal oscillator or external square wave
// - high sides stay on through blank time before short detection
// - error high on overcurrent or overtemperature; standby clears the overcurrent latch, not overtemperature
// - sense already tripped at period start sends bridge straight to slow decay
// - chopper comparators ignored during blanking after switching
// - mixed decay enable pins are active low
module dbc_chopper
  import dbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_ext_in,
  input wire logic polarity_a,
  input wire logic polarity_b,
  input wire logic bridge_a_mixed_decay_enable_n,
  input wire logic bridge_b_mixed_decay_enable_n,
  input wire logic bridge_a_sense_input,
  input wire logic bridge_b_sense_input,
  input wire logic [9:0] supply_drop_mv,
  input wire logic over_temperature,
  input wire logic standby_request,
  output dbc_gate_t gate_a,
  output dbc_gate_t gate_b,
  output logic error_out
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // gate pattern for a phase; polarity low drives leg1 high, leg2 low
  function automatic dbc_gate_t gate_of(input dbc_phase_t ph,
                                        input logic pol);
    dbc_gate_t g;
    g = '0;
    case (ph)
      PH_ON: begin
        g.hs1 = ~pol;
        g.hs2 = pol;
        g.ls1 = pol;
        g.ls2 = ~pol;
      end
      PH_FAST: begin
        g.ls1 = ~pol; // high sides off, low side of the leg the on phase drives high
        g.ls2 = pol;
      end
      PH_SLOW: begin
        g.ls1 = 1'b1; // both low sides
        g.ls2 = 1'b1;
      end
      default: g = '0;
    endcase
    return g;
  endfunction

  // saturating fast decay length: longer on time, shorter fast decay
  function automatic logic [15:0] fast_len(input logic [15:0] fmax,
                                           input logic [15:0] on_len);
    if (fmax > on_len + 16'h0001) begin
      return fmax - on_len;
    end
    return 16'h0001;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic osc_int_sel_q;
  logic [15:0] osc_half_q;
  logic [7:0] blank_q;
  logic [15:0] fast_max_q;
  logic [15:0] div_cnt_q;
  logic osc_int_q;
  logic osc_prev_q;
  logic osc_now;
  logic [1:0] start;
  logic oc_now;
  logic err_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic hit;
  logic wr_en;
  logic [15:0] half_eff;
  dbc_bridge_in_t [1:0] bin;
  dbc_phase_t [1:0] ph_q;
  logic [1:0] pol_q;
  logic [1:0] oc_err_q;
  logic [15:0] cnt_q [2];
  logic [15:0] fast_tgt_q [2];
  dbc_gate_t [1:0] gate_q;

  assign bin[0] = '{polarity_a, bridge_a_mixed_decay_enable_n,
                    bridge_a_sense_input};
  assign bin[1] = '{polarity_b, bridge_b_mixed_decay_enable_n,
                    bridge_b_sense_input};

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------

  // decode of the mapped addresses
  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    case (paddr)
      ADDR_CTRL: rd_mux[CTRL_OSC_INT_BIT] = osc_int_sel_q;
      ADDR_OSC_HALF: rd_mux[15:0] = osc_half_q;
      ADDR_BLANK: rd_mux[7:0] = blank_q;
      ADDR_FAST: rd_mux[15:0] = fast_max_q;
      ADDR_STATUS: begin
        rd_mux[ST_PH_A_LSB +: 2] = ph_q[0];
        rd_mux[ST_PH_B_LSB +: 2] = ph_q[1];
        rd_mux[ST_OC_A_BIT] = oc_err_q[0];
        rd_mux[ST_OC_B_BIT] = oc_err_q[1];
        rd_mux[ST_TEMP_BIT] = over_temperature;
        rd_mux[ST_ERR_BIT] = err_q;
        rd_mux[ST_OSC_BIT] = osc_prev_q;
      end
      default: hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign prdata = prdata_q;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable) begin
      prdata_q <= rd_mux;
    end
  end

  // software writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_int_sel_q <= CTRL_OSC_INT_RST;
      osc_half_q <= OSC_HALF_RST;
      blank_q <= BLANK_RST;
      fast_max_q <= FAST_RST;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: osc_int_sel_q <= pwdata[CTRL_OSC_INT_BIT];
        ADDR_OSC_HALF: osc_half_q <= pwdata[15:0];
        ADDR_BLANK: blank_q <= pwdata[7:0];
        ADDR_FAST: fast_max_q <= pwdata[15:0];
        default: osc_half_q <= osc_half_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // chopper oscillator
  // ---------------------------------------------------------------

  // internal oscillator never runs above the legal maximum
  assign half_eff = (osc_half_q < OSC_HALF_MIN) ? OSC_HALF_MIN
                                                : osc_half_q;

  // internal divider toggles every half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
      osc_int_q <= 1'b0;
    end else if (div_cnt_q >= half_eff - 16'h0001) begin
      div_cnt_q <= '0;
      osc_int_q <= ~osc_int_q;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // source select, then edges split the two bridges
  assign osc_now = osc_int_sel_q ? osc_int_q : osc_ext_in;
  assign start[0] = osc_now & ~osc_prev_q;
  assign start[1] = ~osc_now & osc_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_now;
    end
  end

  // ---------------------------------------------------------------
  // overcurrent comparator and error output
  // ---------------------------------------------------------------
  assign oc_now = supply_drop_mv > OC_DROP_MV;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= (|oc_err_q) | over_temperature;
    end
  end
  assign error_out = err_q;

  // ---------------------------------------------------------------
  // per bridge phase sequencer
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_br
    logic restart;
    logic blanked;
    logic mixed;
    assign restart = bin[i].polarity != pol_q[i];
    assign blanked = cnt_q[i] < {8'h00, blank_q};
    assign mixed = ~bin[i].mixed_decay_enable_n;

    // phase, counters and latched overcurrent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ph_q[i] <= PH_OFF;
        pol_q[i] <= 1'b0;
        oc_err_q[i] <= 1'b0;
        cnt_q[i] <= '0;
        fast_tgt_q[i] <= '0;
      end else begin
        pol_q[i] <= bin[i].polarity;
        if (standby_request) begin
          ph_q[i] <= PH_OFF;
          oc_err_q[i] <= 1'b0;
          cnt_q[i] <= '0;
        end else if (oc_err_q[i]) begin
          ph_q[i] <= PH_OFF;
        end else if (start[i] || restart) begin
          cnt_q[i] <= '0;
          ph_q[i] <= bin[i].sense ? PH_SLOW : PH_ON;
        end else begin
          case (ph_q[i])
            PH_ON: begin
              cnt_q[i] <= cnt_q[i] + 16'h0001;
              if (!blanked) begin
                if (oc_now) begin
                  oc_err_q[i] <= 1'b1;
                  ph_q[i] <= PH_OFF;
                end else if (bin[i].sense) begin
                  cnt_q[i] <= '0;
                  fast_tgt_q[i] <= fast_len(fast_max_q, cnt_q[i]);
                  ph_q[i] <= mixed ? PH_FAST : PH_SLOW;
                end
              end
            end
            PH_FAST: begin
              cnt_q[i] <= cnt_q[i] + 16'h0001;
              if (cnt_q[i] + 16'h0001 >= fast_tgt_q[i]) begin
                ph_q[i] <= PH_SLOW;
              end
            end
            PH_SLOW: cnt_q[i] <= cnt_q[i];
            default: ph_q[i] <= PH_OFF;
          endcase
        end
      end
    end

    // registered gate drive
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gate_q[i] <= '0;
      end else begin
        gate_q[i] <= gate_of(ph_q[i], pol_q[i]);
      end
    end
  end

  assign gate_a = gate_q[0];
  assign gate_b = gate_q[1];

endmodule // dbc_chopper

`default_nettype wire

// ---- design/dbc_pkg.sv ----
// constants and types shared by the dual bridge chopper control
package dbc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned PCLK_HZ = 20_000_000;
  localparam int unsigned OSC_MAX_HZ = 100_000;
  // shortest legal oscillator half period, in pclk cycles
  localparam logic [15:0] OSC_HALF_MIN = 16'(PCLK_HZ / (2 * OSC_MAX_HZ));
  // high side drop that counts as overcurrent to ground, in mV
  localparam logic [9:0] OC_DROP_MV = 10'h096;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_OSC_HALF = 12'h004;
  localparam logic [11:0] ADDR_BLANK = 12'h008;
  localparam logic [11:0] ADDR_FAST = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;

  // control fields and reset values
  localparam int unsigned CTRL_OSC_INT_BIT = 0;
  localparam logic CTRL_OSC_INT_RST = 1'b1;
  localparam logic [15:0] OSC_HALF_RST = 16'h01f4;
  localparam logic [7:0] BLANK_RST = 8'h14;
  localparam logic [15:0] FAST_RST = 16'h00c8;

  // status field positions
  localparam int unsigned ST_PH_A_LSB = 0;
  localparam int unsigned ST_PH_B_LSB = 2;
  localparam int unsigned ST_OC_A_BIT = 4;
  localparam int unsigned ST_OC_B_BIT = 5;
  localparam int unsigned ST_TEMP_BIT = 6;
  localparam int unsigned ST_ERR_BIT = 7;
  localparam int unsigned ST_OSC_BIT = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_OFF, PH_ON, PH_FAST, PH_SLOW} dbc_phase_t;

  // gate drive of one full bridge, leg 1 and leg 2
  typedef struct packed {
    logic hs1;
    logic hs2;
    logic ls1;
    logic ls2;
  } dbc_gate_t;

  // per bridge inputs from controller and sense comparator
  typedef struct packed {
    logic polarity;
    logic mixed_decay_enable_n;
    logic sense;
  } dbc_bridge_in_t;

endpackage

// ---- dv/dbc_coil_model.sv ----
// behavioural coil with its sense comparator behind one bridge
`timescale 1ns/1ps
`default_nettype none
module dbc_coil_model
  import dbc_pkg::*;
(
  input wire logic pclk,
  input wire dbc_gate_t gate,
  input wire logic [15:0] trip_len,
  output logic sense
);
  logic [15:0] cnt_q;
  logic on_w;
  // current only builds while one diagonal of the bridge conducts
  assign on_w = (gate.hs1 && gate.ls2) || (gate.hs2 && gate.ls1);
  // any decay pattern drops the current below the trip level
  always_ff @(posedge pclk) begin
    cnt_q <= on_w ? cnt_q + 16'h0001 : 16'h0000;
  end
  assign sense = (cnt_q >= trip_len); // comparator trips at the target
endmodule // dbc_coil_model
`default_nettype wire

// ---- dv/dbc_chopper_properties.sv ----
// port level assertions for the dual bridge chopper
`timescale 1ns/1ps
`default_nettype none
module dbc_chopper_properties
  import dbc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic polarity_a,
  input wire logic bridge_a_mixed_decay_enable_n,
  input wire logic bridge_b_mixed_decay_enable_n,
  input wire logic bridge_a_sense_input,
  input wire logic [9:0] supply_drop_mv,
  input wire logic over_temperature,
  input wire logic standby_request,
  input wire dbc_gate_t gate_a,
  input wire dbc_gate_t gate_b,
  input wire logic error_out
);
  logic fa, fb, sa;
  // one low side alone is fast decay, both low sides is slow decay
  assign fa = !gate_a.hs1 && !gate_a.hs2 && (gate_a.ls1 != gate_a.ls2);
  assign fb = !gate_b.hs1 && !gate_b.hs2 && (gate_b.ls1 != gate_b.ls2);
  assign sa = (gate_a == 4'b0011);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  no_fast_a_a: assert property (
    $rose(fa) |-> !$past(bridge_a_mixed_decay_enable_n, 2))
    else $error("fast decay on bridge a without mixed decay");
  no_fast_b_a: assert property (
    $rose(fb) |-> !$past(bridge_b_mixed_decay_enable_n, 2))
    else $error("fast decay on bridge b without mixed decay");
  fast_side_a: assert property (
    fa && $stable(polarity_a) && $past(polarity_a, 2) == polarity_a
    |-> gate_a.ls1 != polarity_a)
    else $error("fast decay uses the wrong low side");
  decay_order_a: assert property (
    fa ##1 (!fa && $past(polarity_a, 2) == $past(polarity_a, 3))
    |-> sa || gate_a == 4'h0)
    else $error("fast decay not followed by slow decay");
  pol_restart_a: assert property (
    ($changed(polarity_a) && !bridge_a_sense_input && !standby_request
    && !error_out && supply_drop_mv <= OC_DROP_MV)
    ##1 (!bridge_a_sense_input && !standby_request)
    |-> ##1 (gate_a.hs1 == !$past(polarity_a, 2)
    && gate_a.hs1 != gate_a.hs2 && gate_a.ls2 == gate_a.hs1))
    else $error("polarity change did not restart bridge a");
  err_temp_a: assert property (
    over_temperature ##1 over_temperature |-> error_out)
    else $error("error output low while die is hot");
  err_clear_a: assert property (
    (standby_request && !over_temperature) [*3] |-> !error_out)
    else $error("standby did not clear the error output");
  err_cause_a: assert property (
    $rose(error_out) |-> $past(over_temperature)
    || $past(over_temperature, 2) || $past(supply_drop_mv) > OC_DROP_MV
    || $past(supply_drop_mv, 2) > OC_DROP_MV)
    else $error("error output rose without a cause");
endmodule // dbc_chopper_properties
bind dbc_chopper dbc_chopper_properties i_props (
  .pclk, .presetn, .polarity_a, .bridge_a_mixed_decay_enable_n,
  .bridge_b_mixed_decay_enable_n, .bridge_a_sense_input, .supply_drop_mv,
  .over_temperature, .standby_request, .gate_a, .gate_b, .error_out
);
`default_nettype wire

// ---- dv/tb_top.sv ----
// bench for the dual bridge chopper with two coil models
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dbc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, error_out, sns_a, sns_b;
  logic osc_ext_in = 1'b0, polarity_a = 1'b0, polarity_b = 1'b0;
  logic bridge_a_mixed_decay_enable_n = 1'b1;
  logic bridge_b_mixed_decay_enable_n = 1'b1;
  logic bridge_a_sense_input, bridge_b_sense_input, frc_a = 1'b0;
  logic over_temperature = 1'b0, standby_request = 1'b0;
  logic [9:0] supply_drop_mv = 10'h000;
  logic [15:0] trip = 16'h000a;
  dbc_gate_t gate_a, gate_b;
  int errors = 0, total_checks = 0, n_on, n_fs, fst, f1;
  // 20 mhz clock and sense lines, a with a forced trip
  always #25 pclk = ~pclk;
  assign bridge_a_sense_input = sns_a | frc_a;
  assign bridge_b_sense_input = sns_b;
  dbc_chopper i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .osc_ext_in, .polarity_a, .polarity_b,
    .bridge_a_mixed_decay_enable_n, .bridge_b_mixed_decay_enable_n,
    .bridge_a_sense_input, .bridge_b_sense_input, .supply_drop_mv,
    .over_temperature, .standby_request, .gate_a, .gate_b, .error_out
  );
  dbc_coil_model i_coil_a (.pclk, .gate(gate_a), .trip_len(trip),
                           .sense(sns_a));
  dbc_coil_model i_coil_b (.pclk, .gate(gate_b), .trip_len(trip),
                           .sense(sns_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one oscillator edge, then count on and fast cycles of its bridge
  task automatic half(input logic v);
    dbc_gate_t g;
    logic p;
    n_on = 0;
    n_fs = 0;
    fst = 0;
    osc_ext_in <= v;
    for (int i = 1; i <= 100; i++) begin
      @(posedge pclk);
      g = v ? gate_a : gate_b;
      p = v ? polarity_a : polarity_b;
      if (g.hs1 || g.hs2) n_on++;
      if ((g.hs1 || g.hs2) && fst == 0) fst = i;
      if (g == {2'b00, ~p, p}) n_fs++;
    end
  endtask
  task automatic t_regs();
    logic [11:0] ad [4] = '{ADDR_CTRL, ADDR_OSC_HALF, ADDR_BLANK, ADDR_FAST};
    logic [31:0] ex [4] = '{32'(CTRL_OSC_INT_RST), 32'(OSC_HALF_RST),
      32'(BLANK_RST), 32'(FAST_RST)};
    foreach (ad[i]) begin
      apb(1'b0, ad[i], 32'h0);
      chk(rd, ex[i]);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_BLANK, 32'h4);
    apb(1'b1, ADDR_FAST, 32'h28);
    apb(1'b0, ADDR_BLANK, 32'h0);
    chk(rd, 32'h4);
  endtask
  task automatic t_start();
    trip <= 16'h0002;
    half(1'b1);
    chk(fst, 3);
    chk(32'(n_on >= 4 && n_on <= 8), 32'h1);
    chk(n_fs, 0);
    chk(32'(gate_a), 32'h3);
    half(1'b0);
    chk(fst, 3);
    chk(32'(gate_b), 32'h3);
  endtask
  task automatic t_mix();
    trip <= 16'h000a;
    bridge_a_mixed_decay_enable_n <= 1'b0;
    bridge_b_mixed_decay_enable_n <= 1'b0;
    half(1'b1);
    f1 = n_fs;
    chk(32'(f1 > 0), 32'h1);
    chk(32'(n_on + n_fs >= 38 && n_on + n_fs <= 42), 32'h1);
    half(1'b0);
    chk(32'(n_fs > 0), 32'h1);
    trip <= 16'h0014;
    half(1'b1);
    chk(32'(n_fs > 0 && n_fs < f1), 32'h1);
    half(1'b0);
    bridge_a_mixed_decay_enable_n <= 1'b1;
    bridge_b_mixed_decay_enable_n <= 1'b1;
  endtask
  task automatic t_pol();
    polarity_a <= 1'b1;
    polarity_b <= 1'b1;
    bridge_a_mixed_decay_enable_n <= 1'b0;
    cyc(3);
    chk(32'(gate_a), 32'h6);
    chk(32'(gate_b), 32'h6);
    half(1'b1);
    chk(32'(n_fs > 0), 32'h1);
    half(1'b0);
    bridge_a_mixed_decay_enable_n <= 1'b1;
    frc_a <= 1'b1;
    half(1'b1);
    chk(n_on, 0);
    frc_a <= 1'b0;
    half(1'b0);
  endtask
  task automatic stby();
    standby_request <= 1'b1;
    cyc(4);
    chk(32'(error_out), 32'h0);
    chk(32'(gate_a), 32'h0);
    standby_request <= 1'b0;
    cyc(1);
  endtask
  task automatic t_err();
    over_temperature <= 1'b1;
    cyc(3);
    chk(32'(error_out), 32'h1);
    over_temperature <= 1'b0;
    stby();
    for (int d = OC_DROP_MV; d <= OC_DROP_MV + 1; d++) begin
      supply_drop_mv <= 10'(d);
      half(1'b1);
      supply_drop_mv <= 10'h000;
      chk(32'(error_out), 32'(d > OC_DROP_MV));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, (d > OC_DROP_MV) ? 32'h19c : 32'h103);
      stby();
      half(1'b0);
    end
  endtask
  // internal oscillator with its half period written below the floor
  task automatic t_osc();
    logic pa, pb, na, nb;
    int ka, a1, a2, b1;
    pa = 1'b1;
    pb = 1'b1;
    ka = 0;
    a1 = 0;
    a2 = 0;
    b1 = 0;
    apb(1'b1, ADDR_OSC_HALF, 32'h10);
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 1; i <= 700; i++) begin
      @(posedge pclk);
      na = gate_a.hs1 | gate_a.hs2;
      nb = gate_b.hs1 | gate_b.hs2;
      if (na && !pa) begin
        ka++;
        if (ka == 2) a1 = i;
        if (ka == 3) a2 = i;
      end
      if (nb && !pb && ka == 2 && b1 == 0) b1 = i;
      pa = na;
      pb = nb;
    end
    chk(a2 - a1, 200);
    chk(b1 - a1, 100);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // reset for 16 cycles, then the scenarios in turn
  initial begin
    cyc(16);
    presetn <= 1'b1;
    cyc(1);
    t_regs();
    t_start();
    t_mix();
    t_pol();
    t_err();
    t_osc();
    end_sim();
  end
  // watchdog well beyond the expected run length
  initial begin
    cyc(20000);
    errors++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
